// ==== design/sfc_fifo_ctrl.v ====
// Purpose: 128-entry circular sample buffer with its control and status registers
// Assumes: One clock, synchronous active-high reset, byte register port strobes
// Notes: A two-entry skid buffer sits between the sample source and the array
// Operation
// - 7-bit write index names next slot, advances per stored sample
// - 7-bit read index names next host sample, advances per non-empty data read
// - Host may write read index to reread; almost-full results are host's risk
// - Count lost samples while full, new or old, saturating at 0x7F
// - Occupancy count rises per store below full, falls per non-empty data read
// - Reading data register returns next buffered byte and pops it
// - 7-bit threshold of free entries for almost-full, reset 0x3F
// - Capacity 128; threshold N trips at 128 minus N stored
// - Flush write empties buffer, zeroes indexes and count, self-clears
// - Clear-select 0: flags clear only on status read
// - Clear-select 1: flags clear on data read or status read
// - Repeat type: almost-full reasserts on every store while condition holds
// - Once type: almost-full asserts only on new almost-full condition
// - Roll-over on full: store anyway, both indexes advance
// - Stop on full: drop sample, write index holds
// - Proximity mode stores even when full, ignoring roll-over
// - Separate enables gate temperature-ready and supply-range interrupts
// - Enable two bit 0 gates authentication interrupt, resets disabled
// - Enable one bits 7 and 6 gate almost-full and data-ready, reset off
`timescale 1ns/1ns
`include "sfc_map.vh"
module sfc_fifo_ctrl #(
  parameter DW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sample source
  input wire sampleValid,
  input wire [DW-1:0] sampleData,
  output reg sampleReady_q,
  input wire proxMode,
  // Register port
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWrData,
  input wire regRead,
  output reg [7:0] regRdData_q,
  output reg regRdValid_q,
  // Status register read strobe
  input wire statusRead,
  // Event inputs gated by enables
  input wire tempReadyEvt,
  input wire supplyRangeEvt,
  input wire authDoneEvt,
  // Flags and gated interrupts
  output reg aFullFlag_q,
  output reg dataReadyFlag_q,
  output reg aFullIrq_q,
  output reg dataReadyIrq_q,
  output reg tempIrq_q,
  output reg supplyIrq_q,
  output reg authIrq_q
);

  reg [DW-1:0] mem [0:127];
  reg [6:0] writeIndex_q;
  reg [6:0] readIndex_q;
  reg [6:0] lostCount_q;
  reg [7:0] occupancy_q;
  reg [6:0] thresh_q;
  reg clearSelect_q;
  reg aFullType_q;
  reg rollOver_q;
  reg aFullEn_q;
  reg dataReadyEn_q;
  reg tempEn_q;
  reg supplyEn_q;
  reg authEn_q;
  reg aFullCond_q;
  // Skid buffer
  reg [DW-1:0] skid0_q;
  reg [DW-1:0] skid1_q;
  reg [1:0] skidCnt_q;

  reg [1:0] skidCnt_d;
  reg [DW-1:0] skid0_d;
  reg [DW-1:0] skid1_d;
  reg [6:0] writeIndex_d;
  reg [6:0] readIndex_d;
  reg [6:0] lostCount_d;
  reg [7:0] occupancy_d;
  reg aFullCond_d;
  reg aFullFlag_d;
  reg dataReadyFlag_d;

  wire wrHit = regWrite;
  wire flushReq = wrHit && regAddr == `SFC_ADDR_CFG2 && regWrData[`SFC_BIT_FLUSH];
  wire rdIdxWrite = wrHit && regAddr == `SFC_ADDR_RD_IDX;
  wire dataRead = regRead && regAddr == `SFC_ADDR_DATA;
  wire isFull = occupancy_q == `SFC_DEPTH;
  // Drain stalls while the host touches the buffer state
  // so array writes never meet a pop or a pointer write
  wire drainReady = !flushReq && !rdIdxWrite && !dataRead;
  wire drainValid = skidCnt_q != 2'd0;
  wire drain = drainValid && drainReady;
  wire fill = sampleValid && sampleReady_q;
  // Overwrite on full: the oldest entry goes and the read index follows
  wire storeFull = drain && isFull && (rollOver_q || proxMode);
  wire dropFull = drain && isFull && !rollOver_q && !proxMode;
  wire store = drain && !dropFull;
  wire isEmpty = occupancy_q == 8'h00;
  // Empty data reads show the slot at the read index but never pop
  wire popData = dataRead && !isEmpty;
  wire clearFlags = statusRead || (dataRead && clearSelect_q);

  function [7:0] regView;
    input [6:0] v;
    begin
      regView = {1'b0, v};
    end
  endfunction

  // Indexes wrap at the array size
  function [6:0] nextIndex;
    input [6:0] v;
    begin
      nextIndex = v + 7'd1;
    end
  endfunction

  // Almost-full test: free entries left no more than threshold
  function aFullHit;
    input [7:0] occ;
    input [6:0] thr;
    begin
      aFullHit = occ >= (`SFC_DEPTH - {1'b0, thr});
    end
  endfunction

  // Saturating loss count
  function [6:0] satInc;
    input [6:0] v;
    begin
      if (v == `SFC_LOST_MAX) begin
        satInc = v;
      end else begin
        satInc = v + 7'd1;
      end
    end
  endfunction

  // Skid buffer occupancy and ready
  always @* begin
    skidCnt_d = skidCnt_q;
    if (fill && !drain) begin
      skidCnt_d = skidCnt_q + 2'd1;
    end else if (drain && !fill) begin
      skidCnt_d = skidCnt_q - 2'd1;
    end
  end

  // Skid buffer contents; the head is always skid0
  always @* begin
    skid0_d = skid0_q;
    skid1_d = skid1_q;
    if (drain) begin
      if (skidCnt_q == 2'd2) begin
        skid0_d = skid1_q;
      end else begin
        skid0_d = sampleData;
      end
      if (fill) begin
        skid1_d = sampleData;
      end
    end else if (fill) begin
      if (skidCnt_q == 2'd0) begin
        skid0_d = sampleData;
      end else begin
        skid1_d = sampleData;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      skidCnt_q <= 2'd0;
      sampleReady_q <= 1'b0;
      skid0_q <= {DW{1'b0}};
      skid1_q <= {DW{1'b0}};
    end else begin
      skidCnt_q <= skidCnt_d;
      sampleReady_q <= skidCnt_d != 2'd2;
      skid0_q <= skid0_d;
      skid1_q <= skid1_d;
    end
  end

  // Head of skid buffer is skid0 whenever it holds a word
  always @(posedge clk) begin
    if (store) begin
      mem[writeIndex_q] <= skid0_q;
    end
  end

  // Index, count and loss arithmetic
  always @* begin
    writeIndex_d = writeIndex_q;
    readIndex_d = readIndex_q;
    lostCount_d = lostCount_q;
    occupancy_d = occupancy_q;
    if (flushReq) begin
      writeIndex_d = 7'h00;
      readIndex_d = 7'h00;
      occupancy_d = 8'h00;
    end else if (rdIdxWrite) begin
      readIndex_d = regWrData[6:0];
      // Equal indexes after a pointer write read as empty, never full
      occupancy_d = {1'b0, writeIndex_q - regWrData[6:0]};
    end else if (popData) begin
      readIndex_d = nextIndex(readIndex_q);
      occupancy_d = occupancy_q - 8'd1;
    end else if (store) begin
      writeIndex_d = nextIndex(writeIndex_q);
      if (storeFull) begin
        readIndex_d = nextIndex(readIndex_q);
      end else begin
        occupancy_d = occupancy_q + 8'd1;
      end
    end
    if (storeFull || dropFull) begin
      lostCount_d = satInc(lostCount_q);
    end
  end

  // Almost-full and data-ready flags
  always @* begin
    aFullCond_d = aFullCond_q;
    aFullFlag_d = aFullFlag_q;
    dataReadyFlag_d = dataReadyFlag_q;
    // Clear first; a store in the same cycle sets again and wins
    if (clearFlags) begin
      aFullFlag_d = 1'b0;
      dataReadyFlag_d = 1'b0;
    end
    if (flushReq) begin
      aFullCond_d = 1'b0;
    end else if (store) begin
      aFullCond_d = aFullHit(occupancy_d, thresh_q);
      dataReadyFlag_d = 1'b1;
      if (aFullCond_d && (!aFullType_q || !aFullCond_q)) begin
        aFullFlag_d = 1'b1;
      end
    end else if (popData || rdIdxWrite) begin
      aFullCond_d = aFullHit(occupancy_d, thresh_q);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      writeIndex_q <= 7'h00;
      readIndex_q <= 7'h00;
      lostCount_q <= 7'h00;
      occupancy_q <= 8'h00;
      aFullCond_q <= 1'b0;
      aFullFlag_q <= 1'b0;
      dataReadyFlag_q <= 1'b0;
    end else begin
      writeIndex_q <= writeIndex_d;
      readIndex_q <= readIndex_d;
      lostCount_q <= lostCount_d;
      occupancy_q <= occupancy_d;
      aFullCond_q <= aFullCond_d;
      aFullFlag_q <= aFullFlag_d;
      dataReadyFlag_q <= dataReadyFlag_d;
    end
  end

  // Configuration and enable registers
  always @(posedge clk) begin
    if (rst) begin
      thresh_q <= `SFC_RST_THRESH;
      clearSelect_q <= 1'b0;
      aFullType_q <= 1'b0;
      rollOver_q <= 1'b0;
      aFullEn_q <= 1'b0;
      dataReadyEn_q <= 1'b0;
      tempEn_q <= 1'b0;
      supplyEn_q <= 1'b0;
      authEn_q <= 1'b0;
    end else if (wrHit) begin
      case (regAddr)
        `SFC_ADDR_IRQ_EN1: begin
          aFullEn_q <= regWrData[`SFC_BIT_AFULL_EN];
          dataReadyEn_q <= regWrData[`SFC_BIT_DRDY_EN];
          tempEn_q <= regWrData[`SFC_BIT_TEMP_EN];
          supplyEn_q <= regWrData[`SFC_BIT_SUPPLY_EN];
        end
        `SFC_ADDR_IRQ_EN2: begin
          authEn_q <= regWrData[`SFC_BIT_AUTH_EN];
        end
        `SFC_ADDR_CFG1: begin
          thresh_q <= regWrData[6:0];
        end
        `SFC_ADDR_CFG2: begin
          // Flush is not stored, so it reads back as zero
          clearSelect_q <= regWrData[`SFC_BIT_CLR_SEL];
          aFullType_q <= regWrData[`SFC_BIT_AFULL_TYPE];
          rollOver_q <= regWrData[`SFC_BIT_ROLL];
        end
        default: begin
        end
      endcase
    end
  end

  // Gated interrupt outputs
  // Next flag values keep irqs in step with the flags
  always @(posedge clk) begin
    if (rst) begin
      aFullIrq_q <= 1'b0;
      dataReadyIrq_q <= 1'b0;
      tempIrq_q <= 1'b0;
      supplyIrq_q <= 1'b0;
      authIrq_q <= 1'b0;
    end else begin
      aFullIrq_q <= aFullFlag_d && aFullEn_q;
      dataReadyIrq_q <= dataReadyFlag_d && dataReadyEn_q;
      tempIrq_q <= tempReadyEvt && tempEn_q;
      supplyIrq_q <= supplyRangeEvt && supplyEn_q;
      authIrq_q <= authDoneEvt && authEn_q;
    end
  end

  // Register read answers one cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      regRdData_q <= 8'h00;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRead;
      if (regRead) begin
        case (regAddr)
          `SFC_ADDR_IRQ_EN1: begin
            regRdData_q <= {aFullEn_q, dataReadyEn_q, 3'b000, tempEn_q, supplyEn_q, 1'b0};
          end
          `SFC_ADDR_IRQ_EN2: begin
            regRdData_q <= {7'h00, authEn_q};
          end
          `SFC_ADDR_WR_IDX: begin
            regRdData_q <= regView(writeIndex_q);
          end
          `SFC_ADDR_RD_IDX: begin
            regRdData_q <= regView(readIndex_q);
          end
          `SFC_ADDR_LOST: begin
            regRdData_q <= regView(lostCount_q);
          end
          `SFC_ADDR_OCC: begin
            regRdData_q <= occupancy_q;
          end
          `SFC_ADDR_DATA: begin
            regRdData_q <= mem[readIndex_q][7:0];
          end
          `SFC_ADDR_CFG1: begin
            regRdData_q <= regView(thresh_q);
          end
          `SFC_ADDR_CFG2: begin
            regRdData_q <= {4'h0, clearSelect_q, aFullType_q, rollOver_q, 1'b0};
          end
          default: begin
            regRdData_q <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule // sfc_fifo_ctrl

// ==== design/sfc_map.vh ====
// Purpose: Register offsets, field positions and reset values of the sample FIFO control
// Assumes: Byte-wide register port with one register per address
// Notes: Definitions only
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
`define SFC_ADDR_IRQ_EN1 8'h02
`define SFC_ADDR_IRQ_EN2 8'h03
`define SFC_ADDR_WR_IDX 8'h04
`define SFC_ADDR_RD_IDX 8'h05
`define SFC_ADDR_LOST 8'h06
`define SFC_ADDR_OCC 8'h07
`define SFC_ADDR_DATA 8'h08
`define SFC_ADDR_CFG1 8'h09
`define SFC_ADDR_CFG2 8'h0A
`define SFC_BIT_AFULL_EN 7
`define SFC_BIT_DRDY_EN 6
`define SFC_BIT_TEMP_EN 2
`define SFC_BIT_SUPPLY_EN 1
`define SFC_BIT_AUTH_EN 0
`define SFC_BIT_FLUSH 4
`define SFC_BIT_CLR_SEL 3
`define SFC_BIT_AFULL_TYPE 2
`define SFC_BIT_ROLL 1
`define SFC_RST_THRESH 7'h3F
`define SFC_LOST_MAX 7'h7F
`define SFC_DEPTH 8'h80
`endif

// ==== test/sfc_fifo_ctrl_properties.sv ====
// Purpose: Port checker for sfc_fifo_ctrl
// Assumes: Bound to the design module
// Notes: Event irqs follow their cause by one edge; flag irqs move with their flag
`timescale 1ns/1ns
module sfc_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Watched ports
  input wire regRead,
  input wire regWrite,
  input wire regRdValid_q,
  input wire statusRead,
  input wire tempReadyEvt,
  input wire authDoneEvt,
  input wire tempIrq_q,
  input wire authIrq_q,
  input wire aFullFlag_q,
  input wire aFullIrq_q,
  input wire dataReadyFlag_q,
  input wire dataReadyIrq_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_read_answer: assert property (regRead |=> regRdValid_q) else $error("no answer");
  a_answer_cause: assert property (regRdValid_q |-> $past(regRead)) else $error("stray");
  a_temp_gate: assert property (tempIrq_q |-> $past(tempReadyEvt)) else $error("temp");
  a_auth_gate: assert property (authIrq_q |-> $past(authDoneEvt)) else $error("auth");
  a_afull_gate: assert property (aFullIrq_q |-> aFullFlag_q) else $error("afull");
  a_drdy_gate: assert property (dataReadyIrq_q |-> dataReadyFlag_q) else $error("drdy");
  a_flag_holds: assert property (dataReadyFlag_q && !statusRead && !regRead && !regWrite
    |=> dataReadyFlag_q) else $error("flag lost");
  a_reset_quiet: assert property (disable iff (1'b0) rst
    |=> !aFullIrq_q && !dataReadyIrq_q && !tempIrq_q) else $error("irq in reset");
  c_read: cover property (regRead ##1 regRdValid_q);
  c_afull: cover property ($rose(aFullFlag_q));
  c_temp: cover property (tempIrq_q);
endmodule // sfc_chk
bind sfc_fifo_ctrl sfc_chk chk (.clk, .rst, .regRead, .regWrite, .regRdValid_q, .statusRead,
  .tempReadyEvt, .authDoneEvt, .tempIrq_q, .authIrq_q, .aFullFlag_q, .aFullIrq_q,
  .dataReadyFlag_q, .dataReadyIrq_q);

// ==== test/sfc_sample_src.sv ====
// Purpose: Sample source model
// Assumes: Inputs change at the falling edge
// Notes: Released data shows its inverse
`timescale 1ns/1ns
module sfc_sample_src (
  // Clock and handshake
  input wire clk,
  input wire sampleReady_q,
  output reg sampleValid,
  output reg [7:0] sampleData
);
  initial begin
    sampleValid = 1'b0;
    sampleData = 8'h00;
  end
  // Hold the word until taken
  task send(input [7:0] d);
    begin
      @(negedge clk);
      sampleValid = 1'b1;
      sampleData = d;
      while (sampleReady_q !== 1'b1) @(negedge clk);
      @(negedge clk);
      sampleValid = 1'b0;
      sampleData = ~d;
    end
  endtask
endmodule // sfc_sample_src

// ==== test/tb_sample_fifo_control.sv ====
// Purpose: Self-checking bench for the sample FIFO control
// Assumes: Design samples on the rising edge
// Notes: Queue model mirrors contents and counters
`timescale 1ns/1ns
`include "sfc_map.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_sample_fifo_control;
  reg clk, rst, proxMode, regWrite, regRead, statusRead;
  reg tempReadyEvt, supplyRangeEvt, authDoneEvt, roll;
  reg [7:0] regAddr, regWrData;
  wire sampleValid, sampleReady_q, regRdValid_q, aFullFlag_q, dataReadyFlag_q;
  wire aFullIrq_q, dataReadyIrq_q, tempIrq_q, supplyIrq_q, authIrq_q;
  wire [7:0] sampleData, regRdData_q;
  integer n_errors, checks, seed, wi, ri, lost;
  reg [7:0] q[$];
  reg [7:0] mem[0:127];
  sfc_fifo_ctrl #(.DW(8)) uut (.clk, .rst, .sampleValid, .sampleData, .sampleReady_q,
    .proxMode, .regAddr, .regWrite, .regWrData, .regRead, .regRdData_q, .regRdValid_q,
    .statusRead, .tempReadyEvt, .supplyRangeEvt, .authDoneEvt, .aFullFlag_q,
    .dataReadyFlag_q, .aFullIrq_q, .dataReadyIrq_q, .tempIrq_q, .supplyIrq_q, .authIrq_q);
  sfc_sample_src src (.clk, .sampleReady_q, .sampleValid, .sampleData);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (12000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
  task give_verdict;
    begin
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      `CHK(regRdValid_q, 1'b1)
      `CHK(regRdData_q, e)
    end
  endtask
  task push(input integer n);
    reg [7:0] d;
    begin
      repeat (n) begin
        d = 8'($random(seed));
        repeat ($unsigned($random(seed)) % 3) @(negedge clk);
        src.send(d);
        if (q.size() == 128) begin
          lost = (lost < 127) ? lost + 1 : 127;
          if (roll || proxMode) begin
            void'(q.pop_front());
            ri = (ri + 1) % 128;
          end
        end
        if (q.size() < 128) begin
          q.push_back(d);
          mem[wi] = d;
          wi = (wi + 1) % 128;
        end
      end
      repeat (4) @(negedge clk);
    end
  endtask
  task pop(input integer n);
    repeat (n) begin
      rdc(`SFC_ADDR_DATA, q.pop_front());
      ri = (ri + 1) % 128;
    end
  endtask
  task counts;
    begin
      rdc(`SFC_ADDR_WR_IDX, 8'(wi));
      rdc(`SFC_ADDR_RD_IDX, 8'(ri));
      rdc(`SFC_ADDR_OCC, 8'(q.size()));
    end
  endtask
  task stat;
    begin
      @(negedge clk);
      statusRead = 1'b1;
      @(negedge clk);
      statusRead = 1'b0;
      @(negedge clk);
    end
  endtask
  initial begin
    {n_errors, checks, wi, ri, lost} = 0;
    seed = 47;
    {rst, proxMode, regWrite, regRead, statusRead, roll} = 6'h20;
    {tempReadyEvt, supplyRangeEvt, authDoneEvt, regAddr, regWrData} = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK(sampleReady_q, 1'b1)
    rdc(`SFC_ADDR_CFG1, 8'h3F);
    rdc(`SFC_ADDR_CFG2, 8'h00);
    rdc(`SFC_ADDR_IRQ_EN1, 8'h00);
    rdc(`SFC_ADDR_IRQ_EN2, 8'h00);
    wr(8'h0F, 8'hFF);
    rdc(8'h0F, 8'h00);
    {tempReadyEvt, supplyRangeEvt, authDoneEvt} = 3'h7;
    wr(`SFC_ADDR_IRQ_EN1, 8'hC6);
    wr(`SFC_ADDR_IRQ_EN2, 8'h01);
    rdc(`SFC_ADDR_IRQ_EN1, 8'hC6);
    `CHK({tempIrq_q, supplyIrq_q, authIrq_q}, 3'h7)
    wr(`SFC_ADDR_IRQ_EN1, 8'hC0);
    wr(`SFC_ADDR_IRQ_EN2, 8'h00);
    @(negedge clk);
    `CHK({tempIrq_q, supplyIrq_q, authIrq_q}, 3'h0)
    push(20);
    pop(5);
    counts;
    ri = (ri + 125) % 128;
    wr(`SFC_ADDR_RD_IDX, 8'(ri));
    q.delete();
    for (int k = ri; k != wi; k = (k + 1) % 128) q.push_back(mem[k]);
    pop(3);
    stat;
    wr(`SFC_ADDR_CFG1, 8'd108);
    rdc(`SFC_ADDR_CFG1, 8'd108);
    push(4);
    `CHK(aFullFlag_q, 1'b0)
    push(1);
    `CHK(aFullIrq_q, 1'b1)
    stat;
    push(1);
    `CHK(aFullFlag_q, 1'b1)
    wr(`SFC_ADDR_CFG2, 8'h04);
    stat;
    push(1);
    `CHK(aFullFlag_q, 1'b0)
    pop(1);
    `CHK(dataReadyFlag_q, 1'b1)
    stat;
    `CHK(dataReadyIrq_q, 1'b0)
    wr(`SFC_ADDR_CFG2, 8'h08);
    push(1);
    `CHK(dataReadyFlag_q, 1'b1)
    pop(1);
    `CHK(dataReadyFlag_q, 1'b0)
    wr(`SFC_ADDR_CFG2, 8'h00);
    push(110);
    counts;
    rdc(`SFC_ADDR_LOST, 8'(lost));
    proxMode = 1'b1;
    push(1);
    proxMode = 1'b0;
    counts;
    wr(`SFC_ADDR_CFG2, 8'h12);
    {wi, ri} = 0;
    q.delete();
    rdc(`SFC_ADDR_DATA, mem[0]);
    counts;
    rdc(`SFC_ADDR_CFG2, 8'h02);
    roll = 1'b1;
    push(258);
    counts;
    rdc(`SFC_ADDR_LOST, 8'h7F);
    pop(2);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(sampleReady_q, 1'b0)
    rst = 1'b0;
    {wi, ri, lost} = 0;
    q.delete();
    @(negedge clk);
    `CHK(sampleReady_q, 1'b1)
    counts;
    rdc(`SFC_ADDR_LOST, 8'h00);
    rdc(`SFC_ADDR_CFG1, 8'h3F);
    rdc(`SFC_ADDR_IRQ_EN1, 8'h00);
    give_verdict;
  end
endmodule // tb_sample_fifo_control
